// [src/nbt_defs.vh]
`ifndef NBT_DEFS_VH
`define NBT_DEFS_VH

// Start nibbles seen with the frame strobe low
`define NBT_START_READ 4'hd
`define NBT_START_WRITE 4'he

// Only single-byte transfers exist
`define NBT_SIZE_SINGLE 4'h0

// Codes the target drives back
`define NBT_TURNAROUND 4'hf
`define NBT_WAIT_SYNC 4'h5
`define NBT_READY_SYNC 4'h0

// Cycle numbers, counted from the start cycle as cycle 1
`define NBT_CYC_SELECT 5'h02
`define NBT_CYC_ADDR_FIRST 5'h03
`define NBT_CYC_ADDR_LAST 5'h09
`define NBT_CYC_SIZE 5'h0a
`define NBT_CYC_WDATA_LO 5'h0b
`define NBT_CYC_WDATA_HI 5'h0c
`define NBT_CYC_RD_TAR1 5'h0b
`define NBT_CYC_RD_TAR2 5'h0c
`define NBT_CYC_RD_WAIT2 5'h0e
`define NBT_CYC_RD_READY 5'h0f
`define NBT_CYC_RD_DATA_LO 5'h10
`define NBT_CYC_RD_DATA_HI 5'h11
`define NBT_CYC_RD_CLOSE 5'h12
`define NBT_CYC_WR_TAR1 5'h0d
`define NBT_CYC_WR_TAR2 5'h0e
`define NBT_CYC_WR_SYNC 5'h0f
`define NBT_CYC_WR_CLOSE 5'h10

// Width of a buffered write word: address above data
`define NBT_ADDR_W 28
`define NBT_WORD_W 36

`endif

// [src/nbt_pair_buf.v]
`timescale 1ns/1ps
// Two-entry buffer; both sides valid/ready, outputs straight from flops
module nbt_pair_buf
#(
    parameter WIDTH = 36
)
(
    input wire clock_in, // System clock
    input wire reset_in, // Async reset, active high
    input wire [WIDTH-1:0] in_data_in, // Word offered by the filler
    input wire in_valid_in, // Filler offers a word
    output wire in_ready_out, // Room for a word
    output wire [WIDTH-1:0] out_data_out, // Head word
    output wire out_valid_out, // Head word valid
    input wire out_ready_in // Drainer takes the head word
);

    reg [WIDTH-1:0] head_reg; // Entry seen by the drainer
    reg [WIDTH-1:0] tail_reg; // Second entry, filled only under stall
    reg head_valid_reg; // Head holds a word
    reg tail_valid_reg; // Tail holds a word
    wire push; // Word accepted this cycle
    wire pop; // Word drained this cycle

    // Ready is a flop, so the filler never sees a combinational path
    assign in_ready_out = ~tail_valid_reg;
    assign out_data_out = head_reg;
    assign out_valid_out = head_valid_reg;
    assign push = in_valid_in & ~tail_valid_reg;
    assign pop = head_valid_reg & out_ready_in;

    // Entry bookkeeping
    always @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            head_reg <= {WIDTH{1'b0}};
            tail_reg <= {WIDTH{1'b0}};
            head_valid_reg <= 1'b0;
            tail_valid_reg <= 1'b0;
        end
        else if (!head_valid_reg)
        begin
            // Empty: a new word goes straight to the head
            if (push)
            begin
                head_reg <= in_data_in;
                head_valid_reg <= 1'b1;
            end
        end
        else if (tail_valid_reg)
        begin
            // Full: only a drain moves things, no push possible
            if (pop)
            begin
                head_reg <= tail_reg;
                tail_valid_reg <= 1'b0;
            end
        end
        else if (pop && push)
        begin
            // One in, one out
            head_reg <= in_data_in;
        end
        else if (pop)
        begin
            head_valid_reg <= 1'b0;
        end
        else if (push)
        begin
            // Drainer stalled: park the word
            tail_reg <= in_data_in;
            tail_valid_reg <= 1'b1;
        end
    end

endmodule // nbt_pair_buf

// [src/nbt_target.v]
// Behaviour
// - Frame low with 1101b starts read
// - Frame low with 1110b starts write
// - Cycle two nibble compared with strap pins
// - Seven address nibbles, most significant first
// - Cycle ten size nibble must be 0000b
// - Target takes lines cycle 12/14
// - Read drives 0101b in cycles 13-14
// - Read drives 0000b in cycle 15
// - Read data low nibble then high
// - Read: 1111b cycle 18, float 19
// - Write data cycles 11-12, low first
// - Write drives 0000b sync cycle 15, later after 0101b waits if buffer full
// - Write: 1111b cycle 16, float 17
// - Frame low mid-transfer aborts, floats lines
// - Idle with frame high keeps lines floating
// - Either reset pin low floats, abandons
`timescale 1ns/1ps
`include "nbt_defs.vh"

module nbt_target
(
    input wire clock_in, // Bus clock, 50 MHz
    input wire reset_in, // Async reset, active high
    input wire interface_reset_n_in, // Interface reset pin, active low
    input wire cpu_reset_n_in, // CPU reset pin, active low
    input wire frame_strobe_n_in, // Frame strobe, active low
    input wire [3:0] bus_nibble_lines_in, // Nibble lines as seen on the wire
    output reg [3:0] bus_nibble_lines_out, // Nibble the target drives
    output reg bus_nibble_lines_oe_n_out, // Low while the target drives
    input wire [3:0] strap_id_pins_in, // Strapped identity of this target
    output reg read_strobe_out, // One-cycle read request
    output reg [27:0] read_addr_out, // Address of that read
    input wire [7:0] read_data_in, // Read byte, valid 4 cycles after strobe
    output wire write_valid_out, // Buffered write word valid
    output wire [27:0] write_addr_out, // Address of head write
    output wire [7:0] write_data_out, // Byte of head write
    input wire write_ready_in, // Consumer takes the head write
    output reg busy_out // A transaction is under way
);

    // Transaction phases
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_WRITE = 2'b10;

    reg [1:0] state_reg; // Current phase
    reg [4:0] cyc_reg; // Number of the cycle sampled at the next edge
    reg selected_reg; // Chip select matched
    reg size_ok_reg; // Size nibble was single-byte
    reg [27:0] addr_reg; // Address being assembled
    reg [7:0] wdata_reg; // Write byte being assembled
    reg [7:0] rdata_reg; // Read byte held for the high nibble
    wire in_reset; // Either reset pin asserted
    wire is_start; // Valid start nibble under frame low
    wire active; // Addressed and legal, so may drive
    wire buf_ready; // Room in the write buffer
    wire buf_push; // Write word handed to the buffer
    wire [35:0] buf_out; // Head word of the buffer

    assign in_reset = ~interface_reset_n_in | ~cpu_reset_n_in;
    assign is_start = ~frame_strobe_n_in &
        ((bus_nibble_lines_in == `NBT_START_READ) |
        (bus_nibble_lines_in == `NBT_START_WRITE));
    assign active = selected_reg & size_ok_reg;
    // Push only once the sync is due and room exists
    assign buf_push = (state_reg == ST_WRITE) && (cyc_reg == `NBT_CYC_WR_TAR2) &&
        active && buf_ready && frame_strobe_n_in && !in_reset;
    assign write_addr_out = buf_out[35:8];
    assign write_data_out = buf_out[7:0];

    // Write words wait here so a stalled consumer loses nothing
    nbt_pair_buf
    #(
        .WIDTH(`NBT_WORD_W)
    )
    u_write_buf
    (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .in_data_in({addr_reg, wdata_reg}),
        .in_valid_in(buf_push),
        .in_ready_out(buf_ready),
        .out_data_out(buf_out),
        .out_valid_out(write_valid_out),
        .out_ready_in(write_ready_in)
    );

    // Cycle sequencer; outputs are set one edge ahead of their cycle
    always @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= ST_IDLE;
            cyc_reg <= 5'h00;
            selected_reg <= 1'b0;
            size_ok_reg <= 1'b0;
            addr_reg <= 28'h0000000;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            bus_nibble_lines_out <= 4'hf;
            bus_nibble_lines_oe_n_out <= 1'b1;
            read_strobe_out <= 1'b0;
            read_addr_out <= 28'h0000000;
            busy_out <= 1'b0;
        end
        else
        begin
            read_strobe_out <= 1'b0;
            if (in_reset)
            begin
                // Reset pins hold everything released
                state_reg <= ST_IDLE;
                busy_out <= 1'b0;
                bus_nibble_lines_oe_n_out <= 1'b1;
                bus_nibble_lines_out <= 4'hf;
            end
            else if (is_start && (state_reg == ST_IDLE || !frame_strobe_n_in))
            begin
                // A start, fresh or cutting off an older transaction
                if (bus_nibble_lines_in == `NBT_START_READ)
                    state_reg <= ST_READ;
                else
                    state_reg <= ST_WRITE;
                cyc_reg <= `NBT_CYC_SELECT;
                selected_reg <= 1'b0;
                size_ok_reg <= 1'b0;
                busy_out <= 1'b1;
                bus_nibble_lines_oe_n_out <= 1'b1;
                bus_nibble_lines_out <= 4'hf;
            end
            else if (state_reg == ST_IDLE || !frame_strobe_n_in)
            begin
                // Idle, abort, or an unknown start: stay off the wire
                state_reg <= ST_IDLE;
                busy_out <= 1'b0;
                bus_nibble_lines_oe_n_out <= 1'b1;
                bus_nibble_lines_out <= 4'hf;
            end
            else
            begin
                // Default: step to the next cycle
                cyc_reg <= cyc_reg + 5'h01;
                // Header sampling shared by both directions
                if (cyc_reg == `NBT_CYC_SELECT)
                    selected_reg <= (bus_nibble_lines_in == strap_id_pins_in);
                if (cyc_reg >= `NBT_CYC_ADDR_FIRST && cyc_reg <= `NBT_CYC_ADDR_LAST)
                    addr_reg <= {addr_reg[23:0], bus_nibble_lines_in};
                if (cyc_reg == `NBT_CYC_SIZE)
                    size_ok_reg <= (bus_nibble_lines_in == `NBT_SIZE_SINGLE);
                case (state_reg)
                    ST_READ:
                    begin
                        // Request the byte as soon as the header is complete
                        if (cyc_reg == `NBT_CYC_SIZE && selected_reg &&
                            bus_nibble_lines_in == `NBT_SIZE_SINGLE)
                        begin
                            read_strobe_out <= 1'b1;
                            read_addr_out <= addr_reg;
                        end
                        if (cyc_reg == `NBT_CYC_RD_TAR1)
                        begin
                            // Host drives 1111b now; we take over next cycle
                            bus_nibble_lines_out <= `NBT_TURNAROUND;
                            bus_nibble_lines_oe_n_out <= ~active;
                        end
                        else if (cyc_reg >= `NBT_CYC_RD_TAR2 && cyc_reg < `NBT_CYC_RD_WAIT2)
                            bus_nibble_lines_out <= `NBT_WAIT_SYNC;
                        else if (cyc_reg == `NBT_CYC_RD_WAIT2)
                            bus_nibble_lines_out <= `NBT_READY_SYNC;
                        else if (cyc_reg == `NBT_CYC_RD_READY)
                        begin
                            // Byte captured here and held for its high half
                            rdata_reg <= read_data_in;
                            bus_nibble_lines_out <= read_data_in[3:0];
                        end
                        else if (cyc_reg == `NBT_CYC_RD_DATA_LO)
                            bus_nibble_lines_out <= rdata_reg[7:4];
                        else if (cyc_reg == `NBT_CYC_RD_DATA_HI)
                            bus_nibble_lines_out <= `NBT_TURNAROUND;
                        else if (cyc_reg == `NBT_CYC_RD_CLOSE)
                        begin
                            // Release the wire for the host
                            bus_nibble_lines_oe_n_out <= 1'b1;
                            state_reg <= ST_IDLE;
                            busy_out <= 1'b0;
                        end
                    end
                    ST_WRITE:
                    begin
                        if (cyc_reg == `NBT_CYC_WDATA_LO)
                            wdata_reg[3:0] <= bus_nibble_lines_in;
                        else if (cyc_reg == `NBT_CYC_WDATA_HI)
                            wdata_reg[7:4] <= bus_nibble_lines_in;
                        else if (cyc_reg == `NBT_CYC_WR_TAR1)
                        begin
                            // Host turnaround now; we take over next cycle
                            bus_nibble_lines_out <= `NBT_TURNAROUND;
                            bus_nibble_lines_oe_n_out <= ~active;
                        end
                        else if (cyc_reg == `NBT_CYC_WR_TAR2)
                        begin
                            // A full buffer stretches the sync with wait codes
                            if (buf_ready || !active)
                                bus_nibble_lines_out <= `NBT_READY_SYNC;
                            else
                            begin
                                bus_nibble_lines_out <= `NBT_WAIT_SYNC;
                                cyc_reg <= cyc_reg;
                            end
                        end
                        else if (cyc_reg == `NBT_CYC_WR_SYNC)
                            bus_nibble_lines_out <= `NBT_TURNAROUND;
                        else if (cyc_reg == `NBT_CYC_WR_CLOSE)
                        begin
                            bus_nibble_lines_oe_n_out <= 1'b1;
                            state_reg <= ST_IDLE;
                            busy_out <= 1'b0;
                        end
                    end
                    default:
                    begin
                        state_reg <= ST_IDLE;
                        bus_nibble_lines_oe_n_out <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // nbt_target

// [tb/nbt_target_monitor.sv]
`timescale 1ns/1ps
// Port-level checker for the nibble bus target
module nbt_target_monitor
(
    input wire clock_in, // Bus clock
    input wire reset_in, // Async reset, active high
    input wire interface_reset_n_in, // Interface reset pin
    input wire cpu_reset_n_in, // Cpu reset pin
    input wire frame_strobe_n_in, // Frame strobe
    input wire [3:0] bus_nibble_lines_in, // Resolved lines
    input wire [3:0] bus_nibble_lines_out, // Driven nibble
    input wire bus_nibble_lines_oe_n_out, // Low while driving
    input wire [3:0] strap_id_pins_in, // Strapped identity
    input wire read_strobe_out, // Read request pulse
    input wire [27:0] read_addr_out, // Read address
    input wire [7:0] read_data_in, // Read byte
    input wire write_valid_out, // Buffer head valid
    input wire busy_out // Transaction under way
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    wire pins_ok = interface_reset_n_in && cpu_reset_n_in; // Both pins released
    wire [3:0] nib = bus_nibble_lines_out; // Short alias
    wire oe_n = bus_nibble_lines_oe_n_out; // Short alias
    wire [3:0] li = bus_nibble_lines_in; // Short alias
    // Turnaround, two waits, ready code
    sequence s_rd_sync;
        !oe_n && nib == 4'hf ##1 (nib == 4'h5) [*2] ##1 nib == 4'h0;
    endsequence
    // Byte low nibble first, closing code, then release
    sequence s_rd_data;
        nib == $past(read_data_in[3:0]) ##1 nib == $past(read_data_in[7:4], 2)
            ##1 nib == 4'hf ##1 oe_n;
    endsequence
    // A frame abort or a reset pin may legally cut the reply short
    property p_rd_seq;
        disable iff (reset_in || !frame_strobe_n_in || !pins_ok)
        read_strobe_out |=> s_rd_sync ##1 s_rd_data;
    endproperty
    a_rd_seq: assert property (p_rd_seq) else $error("read reply wrong");
    property p_strobe;
        read_strobe_out |-> $past(li) == 4'h0 && $past(li, 9) == $past(strap_id_pins_in, 9)
            && read_addr_out == {$past(li, 8), $past(li, 7), $past(li, 6), $past(li, 5),
            $past(li, 4), $past(li, 3), $past(li, 2)};
    endproperty
    a_strobe: assert property (p_strobe) else $error("read header wrong");
    property p_wr_close;
        $rose(write_valid_out) |-> !oe_n && nib == 4'h0 ##1 !oe_n && nib == 4'hf ##1 oe_n;
    endproperty
    a_wr_close: assert property (p_wr_close) else $error("write close wrong");
    property p_tar; $fell(oe_n) |-> nib == 4'hf; endproperty
    a_tar: assert property (p_tar) else $error("takeover code wrong");
    property p_start_rd; !busy_out && pins_ok && !frame_strobe_n_in && li == 4'hd |=> busy_out; endproperty
    a_start_rd: assert property (p_start_rd) else $error("read start missed");
    property p_start_wr; !busy_out && pins_ok && !frame_strobe_n_in && li == 4'he |=> busy_out; endproperty
    a_start_wr: assert property (p_start_wr) else $error("write start missed");
    property p_unknown; !busy_out && !frame_strobe_n_in && li != 4'hd && li != 4'he |=> !busy_out;
    endproperty
    a_unknown: assert property (p_unknown) else $error("bad start taken");
    property p_idle; !busy_out |-> oe_n; endproperty
    a_idle: assert property (p_idle) else $error("idle lines driven");
    property p_pins; !pins_ok |=> oe_n && !busy_out; endproperty
    a_pins: assert property (p_pins) else $error("reset pin ignored");
    property p_abort; busy_out && !frame_strobe_n_in |=> oe_n; endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
endmodule // nbt_target_monitor
bind nbt_target nbt_target_monitor u_monitor
(
    .clock_in(clock_in), .reset_in(reset_in), .interface_reset_n_in(interface_reset_n_in),
    .cpu_reset_n_in(cpu_reset_n_in), .frame_strobe_n_in(frame_strobe_n_in),
    .bus_nibble_lines_in(bus_nibble_lines_in), .bus_nibble_lines_out(bus_nibble_lines_out),
    .bus_nibble_lines_oe_n_out(bus_nibble_lines_oe_n_out), .strap_id_pins_in(strap_id_pins_in),
    .read_strobe_out(read_strobe_out), .read_addr_out(read_addr_out),
    .read_data_in(read_data_in), .write_valid_out(write_valid_out), .busy_out(busy_out)
);

// [tb/nbt_host_model.sv]
`timescale 1ns/1ps
// Host controller model: frame, nibbles, and the resolved line level
module nbt_host_model
(
    input wire clock_in, // Bus clock
    input wire [3:0] dut_nibble_in, // Target nibble
    input wire dut_oe_n_in, // Low while target drives
    output reg frame_n_out, // Frame strobe, active low
    output wire [3:0] line_out // Resolved line level
);
    reg [3:0] val_reg = 4'hf; // Host nibble
    reg drive_reg = 1'b1; // Host drives lines
    reg [3:0] last_reg = 4'hf; // Last seen level
    // No pull-ups: a floating line shows a changing pattern, never a held value
    assign line_out = !dut_oe_n_in ? dut_nibble_in : (drive_reg ? val_reg : ~last_reg);
    always @(posedge clock_in) last_reg <= line_out;
    initial frame_n_out = 1'b1;
    // One host cycle, changed at the falling edge
    task cyc(input f, input [3:0] n);
    begin
        @(negedge clock_in);
        frame_n_out = f;
        val_reg = n;
        drive_reg = 1'b1;
    end
    endtask
    // Start, select, address most significant first, size
    task header(input [3:0] s, input [3:0] id, input [27:0] a, input [3:0] sz);
        integer i;
    begin
        cyc(1'b0, s);
        cyc(1'b1, id);
        for (i = 6; i >= 0; i = i - 1)
            cyc(1'b1, a[i*4 +: 4]);
        cyc(1'b1, sz);
    end
    endtask
    // Read: release after turnaround, log cycles 12 to 19
    task rd(input [3:0] id, input [27:0] a, input [3:0] sz, output [31:0] c, output [7:0] o);
        integer k;
    begin
        header(4'hd, id, a, sz);
        cyc(1'b1, 4'hf);
        for (k = 0; k < 8; k = k + 1)
        begin
            @(negedge clock_in);
            drive_reg = 1'b0;
            c[k*4 +: 4] = line_out;
            o[k] = dut_oe_n_in;
        end
    end
    endtask
    // Write: data low nibble first, then log cycles 14 to 17, counting waits
    task wr(input [27:0] a, input [7:0] d, output [11:0] c, output [3:0] o, output integer w);
        integer k;
    begin
        header(4'he, 4'h6, a, 4'h0);
        cyc(1'b1, d[3:0]);
        cyc(1'b1, d[7:4]);
        cyc(1'b1, 4'hf);
        w = 0;
        for (k = 0; k < 4; k = k + 1)
        begin
            @(negedge clock_in);
            drive_reg = 1'b0;
            while (k == 1 && line_out === 4'h5 && w < 40)
            begin
                w = w + 1;
                @(negedge clock_in);
            end
            if (k < 3)
                c[k*4 +: 4] = line_out;
            o[k] = dut_oe_n_in;
        end
    end
    endtask
endmodule // nbt_host_model

// [tb/nibble_bus_target_cycles_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the nibble bus target
module nibble_bus_target_cycles_bench;
    reg clock_in = 1'b0; // 50 MHz bus clock
    reg reset_in = 1'b1; // Async reset
    reg interface_reset_n = 1'b1; // Interface reset pin
    reg cpu_reset_n = 1'b1; // Cpu reset pin
    reg write_ready = 1'b1; // Consumer ready
    wire frame_n, dut_oe_n, read_strobe, write_valid, busy; // Single-bit links
    wire [3:0] line, dut_nib; // Nibble links
    wire [27:0] read_addr, write_addr; // Addresses
    wire [7:0] write_data; // Head byte
    wire [7:0] read_data = read_addr[7:0] ^ 8'ha5; // Memory content follows address
    integer failures = 0; // Mismatch count
    integer checked = 0; // Comparison count
    integer strobes = 0; // Read requests seen by the memory side
    reg [35:0] words [$]; // Accepted write words
    always #10 clock_in = ~clock_in;
    nbt_host_model host (.clock_in(clock_in), .dut_nibble_in(dut_nib), .dut_oe_n_in(dut_oe_n),
        .frame_n_out(frame_n), .line_out(line));
    nbt_target dut (.clock_in(clock_in), .reset_in(reset_in),
        .interface_reset_n_in(interface_reset_n), .cpu_reset_n_in(cpu_reset_n),
        .frame_strobe_n_in(frame_n), .bus_nibble_lines_in(line), .bus_nibble_lines_out(dut_nib),
        .bus_nibble_lines_oe_n_out(dut_oe_n), .strap_id_pins_in(4'h6),
        .read_strobe_out(read_strobe), .read_addr_out(read_addr), .read_data_in(read_data),
        .write_valid_out(write_valid), .write_addr_out(write_addr), .write_data_out(write_data),
        .write_ready_in(write_ready), .busy_out(busy));
    // Consumer logs every word it takes
    always @(posedge clock_in)
        if (write_valid && write_ready)
            words.push_back({write_addr, write_data});
    // Memory side counts read requests
    always @(posedge clock_in)
        if (read_strobe)
            strobes <= strobes + 1;
    task chk(input [63:0] g, input [63:0] e);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task t_read(input [27:0] a);
        reg [31:0] c;
        reg [7:0] o;
        integer n;
    begin
        n = strobes;
        host.rd(4'h6, a, 4'h0, c, o);
        chk(strobes - n, 1);
        chk(c[27:0], {4'hf, a[7:0] ^ 8'ha5, 16'h055f});
        chk(o, 8'h80);
        chk(read_addr, a);
    end
    endtask
    // Writes with room; stalled consumer fills the buffer so the third waits
    task t_writes(input stall);
        reg [11:0] c;
        reg [3:0] o;
        integer w, i;
    begin
        write_ready = !stall;
        for (i = 0; i < 3; i = i + 1)
        fork
            host.wr(28'h0fffff0 + i, 8'hf0 + i, c, o, w);
            if (stall && i == 2)
            begin
                repeat (24) @(negedge clock_in);
                write_ready = 1'b1;
            end
        join
        // Wait codes only when the last write met a full buffer
        chk(w > 0, stall);
        chk(c, 12'hf0f);
        chk(o, 4'h8);
        chk(words.size(), 3);
        for (i = 0; i < 3; i = i + 1)
            chk(words.pop_front(), 36'hfffff0f0 + 36'h101 * i);
        chk(write_valid, 0);
    end
    endtask
    task s_misc;
        reg [31:0] c;
        reg [7:0] o;
        integer i;
    begin
        i = strobes;
        host.rd(4'h9, 28'h0000123, 4'h0, c, o);
        chk(o, 8'hff);
        host.rd(4'h6, 28'h0000123, 4'h1, c, o);
        chk(o, 8'hff);
        chk(strobes - i, 0);
        // Read cut off by the frame strobe while the target drives
        host.header(4'hd, 4'h6, 28'h0000042, 4'h0);
        host.cyc(1'b1, 4'hf);
        host.cyc(1'b1, 4'hf);
        chk(dut_oe_n, 0);
        host.cyc(1'b0, 4'h0);
        @(negedge clock_in);
        chk({busy, dut_oe_n}, 2'b01);
        // Every nibble under frame low; 1101b and 1110b while a reset pin is low, then 1101b with both pins released
        for (i = 0; i < 18; i = i + 1)
        begin
            host.cyc(1'b0, i < 16 ? i[3:0] : (i == 16 ? 4'hd : 4'h0));
            interface_reset_n = (i != 13);
            cpu_reset_n = (i != 14);
            @(negedge clock_in);
            chk({busy, dut_oe_n}, {i == 16, 1'b1});
        end
        host.cyc(1'b0, 4'hd);
        host.cyc(1'b1, 4'h6);
        t_read(28'h7654321);
    end
    endtask
    initial
    begin
        repeat (12) @(negedge clock_in);
        reset_in = 1'b0;
        t_read(28'h1234567);
        t_read(28'hfedcba9);
        t_writes(1'b0);
        s_misc;
        t_writes(1'b1);
        print_verdict;
    end
    initial
    begin
        #100000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // nibble_bus_target_cycles_bench
